/* File: logic/supervisor_cfg.svh */
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH

// Register byte offsets
`define SUP_REG_RST_CAP   8'h00
`define SUP_REG_WD_CAP    8'h04
`define SUP_REG_CONFIG    8'h08
`define SUP_REG_STATUS    8'h0C

// Field positions
`define SUP_CFG_ACT_HIGH  0
`define SUP_ST_RESET      0
`define SUP_ST_UNDERV     1
`define SUP_ST_EXT_MODE   2
`define SUP_ST_WD_OFF     3
`define SUP_ST_WD_CAUSE   4
`define SUP_ST_FLOAT      5

// Reset values
`define SUP_RST_CAP_INIT  16'h05DC
`define SUP_WD_CAP_INIT   16'h05DC
`define SUP_CONFIG_INIT   1'b0

// Timing: 2.67 us per pF, clock period 5 ns
`define SUP_NS_PER_PF_X1000 2670000
`define SUP_CLK_PERIOD_PS   5000
`define SUP_CYC_PER_PF      (`SUP_NS_PER_PF_X1000 / `SUP_CLK_PERIOD_PS)
`define SUP_EXT_MULT        10'h1F4
`define SUP_FLOAT_PCT       7'h5E
`define SUP_PCT_FULL        7'h64

// AXI responses
`define SUP_RESP_OKAY     2'h0
`define SUP_RESP_SLVERR   2'h2

`endif

/* File: logic/supervisor_pkg.sv */
package supervisor_pkg;
	typedef enum logic [1:0] {
		RST_RUN  = 2'b00,
		RST_LOW  = 2'b01,
		RST_HOLD = 2'b10
	} rst_state_t;
endpackage

/* File: logic/supervisor_reset_watchdog.sv */
// Function
// RL1: Assert reset at once on undervoltage.
// RL2: Hold reset while level stays low.
// RL3: After recovery hold one reset timeout.
// RL4: Active-high variant inverts reset output.
// RL5: Reset timeout scales 2.67 us per pF.
// RL6: Watchdog period scales 2.67 us per pF.
// RL7: Zero watchdog capacitance disables watchdog.
// RL8: Extended mode multiplies period by 500.
// RL9: Mode select change clears watchdog timer.
// RL10: Any kick edge clears watchdog timer.
// RL11: Missing kick gives one reset-timeout pulse.
// RL12: Timer held clear while reset asserted.
// RL13: Floating kick in extended mode disables.
// RL14: Expiry and reset pulse repeat until kicked.
// RL15: Floating kick in extended mode pulses internally at 94 percent.
// RL16: One timing clock, inputs synchronised first.
// RL17: Kicks during reset pulse never shorten it.
`timescale 1ns/10ps
`include "supervisor_cfg.svh"

module supervisor_reset_watchdog
	import supervisor_pkg::*;
#(
	parameter int CNT_W      = 40,
	parameter int CYC_PER_PF = `SUP_CYC_PER_PF
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	// AXI4-Lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// Comparator and processor side
	input  wire logic        undervoltage,
	input  wire logic        watchdog_kick_input,
	input  wire logic        watchdog_kick_float,
	input  wire logic        watchdog_mode_select,
	output logic             supervised_reset
);

	function automatic logic [CNT_W-1:0] span(input logic [15:0] pf, input logic [9:0] mult);
		logic [CNT_W-1:0] cyc;
		cyc  = CNT_W'(pf) * CNT_W'(CYC_PER_PF);
		span = cyc * CNT_W'(mult);
	endfunction

	// Synchronisers: stage 1 feeds stage 2 only
	logic [3:0] sync1_ff;
	logic [3:0] sync2_ff;
	logic [3:0] sync3_ff;
	logic       uv_s;
	logic       mode_s;
	logic       float_s;
	logic       kick_edge;
	logic       mode_edge;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_ff <= 4'h0;
			sync2_ff <= 4'h0;
			sync3_ff <= 4'h0;
		end else begin
			sync1_ff <= {watchdog_kick_float, watchdog_mode_select,
				watchdog_kick_input, undervoltage}; // [RL16]
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	assign uv_s      = sync2_ff[0];
	assign mode_s    = sync2_ff[2];
	assign float_s   = sync2_ff[3];
	assign kick_edge = sync2_ff[1] ^ sync3_ff[1]; // [RL10]
	assign mode_edge = sync2_ff[2] ^ sync3_ff[2]; // [RL9]

	// Registers
	logic [15:0] rst_cap_ff;
	logic [15:0] wd_cap_ff;
	logic        act_high_ff;
	logic        wd_cause_ff;

	// Derived limits
	logic [CNT_W-1:0] rp_lim_ff;
	logic [CNT_W-1:0] wd_lim_ff;
	logic [CNT_W-1:0] float_lim_ff;
	logic             wd_off;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Defaults so the power-up hold runs its full length
			rp_lim_ff    <= span(`SUP_RST_CAP_INIT, 10'h001);
			wd_lim_ff    <= span(`SUP_WD_CAP_INIT, 10'h001);
			float_lim_ff <= '0;
		end else begin
			rp_lim_ff    <= span(rst_cap_ff, 10'h001); // [RL5]
			wd_lim_ff    <= span(wd_cap_ff, mode_s ? `SUP_EXT_MULT : 10'h001); // [RL6] [RL8]
			float_lim_ff <= CNT_W'(((CNT_W+7)'(wd_lim_ff) * `SUP_FLOAT_PCT)
				/ `SUP_PCT_FULL); // [RL15]
		end
	end

	// Floating kick only disables in extended mode
	assign wd_off = (wd_cap_ff == 16'h0000) || (mode_s && float_s); // [RL7] [RL13]

	// Reset sequencer
	rst_state_t       rst_state_ff;
	rst_state_t       nxt_rst_state;
	logic [CNT_W-1:0] rst_cnt_ff;
	logic [CNT_W-1:0] wd_cnt_ff;
	logic             wd_expire;
	logic             float_pulse;
	logic             rst_active;

	assign rst_active  = (rst_state_ff != RST_RUN);
	assign wd_expire   = !wd_off && (wd_cnt_ff + CNT_W'(1) >= wd_lim_ff); // [RL11]
	assign float_pulse = mode_s && float_s && (wd_cnt_ff >= float_lim_ff); // [RL15]

	always_comb begin
		nxt_rst_state = rst_state_ff;
		case (rst_state_ff)
			RST_RUN: begin
				if (uv_s)
					nxt_rst_state = RST_LOW; // [RL1]
				else if (wd_expire)
					nxt_rst_state = RST_HOLD; // [RL11] [RL14]
			end
			RST_LOW: begin
				if (!uv_s)
					nxt_rst_state = RST_HOLD; // [RL2] [RL3]
			end
			RST_HOLD: begin
				if (uv_s)
					nxt_rst_state = RST_LOW; // [RL1]
				else if (rst_cnt_ff + CNT_W'(1) >= rp_lim_ff)
					nxt_rst_state = RST_RUN; // [RL3] [RL17]
			end
			default: nxt_rst_state = RST_LOW;
		endcase
	end

	always_ff @(posedge aclk) begin
		// Power-up counts one full timeout before release
		if (!aresetn)
			rst_state_ff <= RST_HOLD;
		else
			rst_state_ff <= nxt_rst_state;
	end

	// Reset timeout counter, ignores kicks
	// Restarts from zero on every entry to hold
	always_ff @(posedge aclk) begin
		if (!aresetn)
			rst_cnt_ff <= '0;
		else if (rst_state_ff != RST_HOLD || nxt_rst_state != RST_HOLD)
			rst_cnt_ff <= '0;
		else
			rst_cnt_ff <= rst_cnt_ff + CNT_W'(1); // [RL17]
	end

	// Watchdog timer; in extended mode a floating kick is held off by the internal pulse
	logic wd_clear;

	assign wd_clear = kick_edge || mode_edge || float_pulse || (wd_cap_ff == 16'h0000);

	always_ff @(posedge aclk) begin
		if (!aresetn)
			wd_cnt_ff <= '0;
		else if (rst_active || nxt_rst_state != RST_RUN)
			wd_cnt_ff <= '0; // [RL12]
		else if (wd_clear)
			wd_cnt_ff <= '0; // [RL9] [RL10] [RL15]
		else
			wd_cnt_ff <= wd_cnt_ff + CNT_W'(1);
	end

	// Cause of the latest reset
	always_ff @(posedge aclk) begin
		if (!aresetn)
			wd_cause_ff <= 1'b0;
		else if (rst_state_ff == RST_RUN && nxt_rst_state == RST_HOLD)
			wd_cause_ff <= 1'b1;
		else if (nxt_rst_state == RST_LOW)
			wd_cause_ff <= 1'b0;
	end

	// Output pin
	// Polarity follows the variant bit
	always_ff @(posedge aclk) begin
		if (!aresetn)
			supervised_reset <= 1'b0;
		else
			supervised_reset <= (nxt_rst_state != RST_RUN) ~^ act_high_ff; // [RL4]
	end

	// AXI4-Lite write path
	logic        aw_held_ff;
	logic        w_held_ff;
	logic [7:0]  aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0]  w_strb_ff;
	logic        do_write;

	// Lands once both halves are held and no response waits
	assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff    <= 1'b0;
			aw_addr_ff    <= 8'h00;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_ff && !(s_axi_awvalid && s_axi_awready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_ff    <= 1'b0;
			w_data_ff    <= 32'h0000_0000;
			w_strb_ff    <= 4'h0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_held_ff && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end else if (do_write) begin
				w_held_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SUP_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			case (aw_addr_ff)
				`SUP_REG_RST_CAP, `SUP_REG_WD_CAP, `SUP_REG_CONFIG,
				`SUP_REG_STATUS: s_axi_bresp <= `SUP_RESP_OKAY;
				default:         s_axi_bresp <= `SUP_RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Register storage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_cap_ff  <= `SUP_RST_CAP_INIT;
			wd_cap_ff   <= `SUP_WD_CAP_INIT;
			act_high_ff <= `SUP_CONFIG_INIT;
		end else if (do_write) begin
			case (aw_addr_ff)
				`SUP_REG_RST_CAP: begin
					if (w_strb_ff[0]) rst_cap_ff[7:0]  <= w_data_ff[7:0];
					if (w_strb_ff[1]) rst_cap_ff[15:8] <= w_data_ff[15:8];
				end
				`SUP_REG_WD_CAP: begin
					if (w_strb_ff[0]) wd_cap_ff[7:0]  <= w_data_ff[7:0];
					if (w_strb_ff[1]) wd_cap_ff[15:8] <= w_data_ff[15:8];
				end
				`SUP_REG_CONFIG: begin
					if (w_strb_ff[0])
						act_high_ff <= w_data_ff[`SUP_CFG_ACT_HIGH]; // [RL4]
				end
				default: ;
			endcase
		end
	end

	// AXI4-Lite read path
	// STATUS shows synchronised levels
	logic [31:0] status_word;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`SUP_ST_RESET]    = rst_active;
		status_word[`SUP_ST_UNDERV]   = uv_s;
		status_word[`SUP_ST_EXT_MODE] = mode_s;
		status_word[`SUP_ST_WD_OFF]   = wd_off;
		status_word[`SUP_ST_WD_CAUSE] = wd_cause_ff;
		status_word[`SUP_ST_FLOAT]    = float_s;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `SUP_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `SUP_RESP_OKAY;
				case (s_axi_araddr)
					`SUP_REG_RST_CAP: s_axi_rdata <= {16'h0000, rst_cap_ff};
					`SUP_REG_WD_CAP:  s_axi_rdata <= {16'h0000, wd_cap_ff};
					`SUP_REG_CONFIG:  s_axi_rdata <= {31'h0, act_high_ff};
					`SUP_REG_STATUS:  s_axi_rdata <= status_word;
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `SUP_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

/* File: dv/supervisor_reset_watchdog_checker.sv */
`timescale 1ns/10ps
module supervisor_reset_watchdog_checker (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Pins
	input wire logic        undervoltage,
	input wire logic        supervised_reset,
	// Bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence held_low;
		!supervised_reset [*8];
	endsequence
	uv_assert_a: assert property ($rose(undervoltage) |-> ##[1:4] !supervised_reset)
		else $error("reset late after undervoltage");
	uv_hold_a: assert property (undervoltage [*4] |-> !supervised_reset)
		else $error("reset released during undervoltage");
	recover_hold_a: assert property ($fell(undervoltage) |=> held_low)
		else $error("reset released early after recovery");
	pulse_min_a: assert property ($fell(supervised_reset) |-> held_low)
		else $error("reset pulse too short");
	write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp))
		else $error("write response dropped");
	read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata))
		else $error("read data dropped");
	ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while busy");
endmodule

bind supervisor_reset_watchdog supervisor_reset_watchdog_checker checker_inst (
	.aclk(aclk), .aresetn(aresetn), .undervoltage(undervoltage),
	.supervised_reset(supervised_reset), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

/* File: dv/proc_model.sv */
`timescale 1ns/10ps
module proc_model (
	// Clock
	input wire logic        aclk,
	// Kick control
	input wire logic [15:0] kick_gap,
	output logic            kick
);
	logic [15:0] cnt_ff  = 16'h0000;
	logic        kick_ff = 1'b0;
	assign kick = kick_ff;
	// Toggle every kick_gap cycles, zero stops the kicks
	always @(posedge aclk) begin
		if (kick_gap != 16'h0000 && cnt_ff >= kick_gap) begin
			kick_ff <= ~kick_ff;
			cnt_ff <= 16'h0001;
		end else
			cnt_ff <= cnt_ff + 16'h0001;
	end
endmodule

/* File: dv/supervisor_reset_watchdog_bench.sv */
`timescale 1ns/10ps
module supervisor_reset_watchdog_bench;
	localparam int RP = 32'h14;
	localparam int WD = 32'h1E;
	logic        aclk, aresetn, uv, kfl, mode, rst, kick;
	logic        awv, awr, wv, wrd, bv, brd, arv, arr, rv, rrd;
	logic [7:0]  awa, ara;
	logic [31:0] wd, rd;
	logic [1:0]  bresp, rresp;
	logic [15:0] gap;
	int          mismatches, comparisons, n;

	always #2.5 aclk = ~aclk;

	supervisor_reset_watchdog #(.CYC_PER_PF(1)) supervisor_reset_watchdog_inst (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_bresp(bresp),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
		.s_axi_rready(rrd), .s_axi_rdata(rd), .s_axi_rresp(rresp), .undervoltage(uv),
		.watchdog_kick_input(kick), .watchdog_kick_float(kfl),
		.watchdog_mode_select(mode), .supervised_reset(rst));
	proc_model proc_model_inst (.aclk(aclk), .kick_gap(gap), .kick(kick));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task rng(input int v, input int lo, input int hi);
		chk((v >= lo && v <= hi) ? lo : v, lo);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		brd <= 1'b1;
		do begin
			@(posedge aclk);
			if (awr === 1'b1) ta = 1'b1;
			if (wrd === 1'b1) tw = 1'b1;
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end while (!(ta && tw));
		do @(posedge aclk); while (bv !== 1'b1);
		brd <= 1'b0;
		chk(32'(bresp), 32'(e));
		@(posedge aclk);
	endtask
	task rdx(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] e);
		ara <= a;
		arv <= 1'b1;
		rrd <= 1'b1;
		do @(posedge aclk); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge aclk); while (rv !== 1'b1);
		rrd <= 1'b0;
		chk(rd, ed);
		chk(32'(rresp), 32'(e));
		@(posedge aclk);
	endtask
	// Cycles until the reset output shows lvl, capped at lim
	task count_until(input logic lvl, input int lim, output int c);
		c = 0;
		while (rst !== lvl && c < lim) begin
			@(posedge aclk);
			c++;
		end
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		#250000;
		mismatches++;
		$display("unexpected at %0t: got %h exp %h", $time, 32'h0, 32'h1);
		finish_test;
	end

	initial begin
		{aclk, aresetn, uv, kfl, mode, awv, wv, brd, arv, rrd} = 10'h000;
		{awa, ara, wd, gap} = {8'h00, 8'h00, 32'h0, 16'h0008};
		{mismatches, comparisons} = {32'h0, 32'h0};
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdx(8'h00, 32'h000005DC, 2'h0);
		rdx(8'h04, 32'h000005DC, 2'h0);
		rdx(8'h08, 32'h00000000, 2'h0);
		wr(8'h00, RP, 2'h0);
		wr(8'h04, WD, 2'h0);
		rdx(8'h04, WD, 2'h0);
		wr(8'h10, 32'hFFFFFFFF, 2'h2);
		rdx(8'h10, 32'h00000000, 2'h2);
		$display("test registers done");
		count_until(1'b1, 4000, n);
		uv <= 1'b1;
		repeat (5) @(posedge aclk);
		chk(32'(rst), 32'h0);
		repeat (60) @(posedge aclk);
		chk(32'(rst), 32'h0);
		uv <= 1'b0;
		count_until(1'b1, 200, n);
		rng(n, RP, RP + 5);
		$display("test undervoltage done");
		gap <= 16'h0000;
		count_until(1'b0, 200, n);
		rng(n, WD - 1, WD + 4);
		count_until(1'b1, 200, n);
		rng(n, RP, RP + 2);
		count_until(1'b0, 200, n);
		rng(n, WD - 1, WD + 4);
		count_until(1'b1, 200, n);
		gap <= 16'h000A;
		count_until(1'b0, 300, n);
		chk(n, 300);
		$display("test watchdog done");
		gap <= 16'h0000;
		mode <= 1'b1;
		count_until(1'b0, 2000, n);
		chk(n, 2000);
		kfl <= 1'b1;
		count_until(1'b0, 16000, n);
		chk(n, 16000);
		kfl <= 1'b0;
		mode <= 1'b0;
		count_until(1'b0, 200, n);
		rng(n, WD - 1, WD + 4);
		count_until(1'b1, 200, n);
		$display("test extended done");
		gap <= 16'h0008;
		wr(8'h04, 32'h00000000, 2'h0);
		gap <= 16'h0000;
		count_until(1'b0, 300, n);
		chk(n, 300);
		rdx(8'h0C, 32'h00000018, 2'h0);
		$display("test disabled done");
		wr(8'h08, 32'h00000001, 2'h0);
		chk(32'(rst), 32'h0);
		rdx(8'h08, 32'h00000001, 2'h0);
		repeat (8) @(posedge aclk);
		wr(8'h08, 32'h00000000, 2'h0);
		chk(32'(rst), 32'h1);
		$display("test polarity done");
		finish_test;
	end
endmodule
